// ---- rtl/serial_irq_pkg.sv ----
// Shared constants and types for the serial controller interrupt gate.
// Assumes a 32-bit AXI4-Lite register bus and two serial controllers.
package serial_irq_pkg;

   // Geometry
   localparam int NUM_CTRL = 2;
   localparam int SRC_W = 15;
   localparam int MODE_W = 3;
   localparam int STROBE_W = SRC_W - MODE_W;

   // Register byte addresses
   localparam logic [31:0] SERIAL1_IRQ_PENDING_ADDR = 32'h4000a840;
   localparam logic [31:0] SERIAL2_IRQ_PENDING_ADDR = 32'h4000a844;
   localparam logic [31:0] SERIAL1_IRQ_ENABLE_ADDR = 32'h4000a848;
   localparam logic [31:0] SERIAL2_IRQ_ENABLE_ADDR = 32'h4000a84c;
   localparam logic [31:0] SERIAL1_IRQ_TRIGGER_MODE_ADDR = 32'h4000a854;
   localparam logic [31:0] SERIAL2_IRQ_TRIGGER_MODE_ADDR = 32'h4000a858;

   // Values after reset
   localparam logic [SRC_W-1:0] ENABLE_RESET = 15'h0000;
   localparam logic [SRC_W-1:0] PENDING_RESET = 15'h0000;
   localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

   // Trigger mode field positions
   localparam int RX_DATA_LEVEL_SEL_BIT = 0;
   localparam int TX_SPACE_LEVEL_SEL_BIT = 1;
   localparam int TX_IDLE_LEVEL_SEL_BIT = 2;

   // Sources without a mode bit are event strobes taken as levels
   localparam logic [STROBE_W-1:0] STROBE_LEVEL = 12'hfff;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Source conditions, bit 14 down to bit 0
   typedef struct packed {
      logic uart_parity_err_irq;
      logic uart_framing_err_irq;
      logic tx_dma_buf_b_unloaded_irq;
      logic tx_dma_buf_a_unloaded_irq;
      logic rx_dma_buf_b_unloaded_irq;
      logic rx_dma_buf_a_unloaded_irq;
      logic twowire_noack_irq;
      logic twowire_cmd_done_irq;
      logic twowire_tx_done_irq;
      logic twowire_rx_done_irq;
      logic tx_underrun_irq;
      logic rx_overrun_irq;
      logic tx_idle_irq;
      logic tx_space_irq;
      logic rx_data_irq;
   } serial_src_type;

   typedef enum logic [1:0] {
      KIND_ENABLE = 2'h0,
      KIND_MODE = 2'h1,
      KIND_PENDING = 2'h3
   } reg_kind_type;

   typedef struct packed {
      logic hit;
      logic ctrl;
      reg_kind_type kind;
   } decode_type;

   typedef enum logic {
      WR_WAIT = 1'b0,
      WR_RESP = 1'b1
   } wr_state_type;

   typedef enum logic {
      RD_WAIT = 1'b0,
      RD_DATA = 1'b1
   } rd_state_type;

endpackage : serial_irq_pkg

// ---- rtl/serial_irq_gate.sv ----
// Second-level interrupt gating for two serial controllers, with an AXI4-Lite slave.
// Assumes source conditions are synchronous to clk and bus traffic only while ce is high.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Enable bit 14 lets the UART parity-error flag raise the interrupt.
// - Enable bit 13 lets the UART framing-error flag raise the interrupt.
// - Enable bits 12 and 11 gate transmit DMA buffer B and A unloaded.
// - Enable bits 10 and 9 gate receive DMA buffer B and A unloaded.
// - Enable bit 8 gates the two-wire not-acknowledge interrupt.
// - Enable bit 7 gates the two-wire start or stop command done interrupt.
// - Enable bit 6 gates the two-wire transmit done interrupt.
// - Enable bit 5 gates the two-wire receive done interrupt.
// - Enable bit 4 gates the transmit underrun interrupt.
// - Enable bit 3 gates the receive overrun interrupt.
// - Enable bit 1 gates transmit space, bit 2 gates transmitter idle.
// - Enable bit 0 gates the receive data available interrupt.
// - Mode bit 2 picks edge (0) or level (1) for transmitter idle.
// - Mode bit 1 picks edge (0) or level (1) for transmit space.
// - Mode bit 0 picks edge (0) or level (1) for receive data.
// - All enable registers read zero after reset.
// - All trigger mode registers read zero after reset.
// - Pending flags per controller sit at the same positions as enables.
module serial_irq_gate (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Source conditions, index 0 is controller 1
   input wire serial_irq_pkg::serial_src_type [1:0] serial_src,
   // Interrupt requests toward the top-level controller
   output logic [1:0] serial_irq,
   // AXI4-Lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // Map a byte address onto a controller and a register kind
   function automatic serial_irq_pkg::decode_type decode_addr(input logic [31:0] addr);
      serial_irq_pkg::decode_type d;
      d = '{hit: 1'b1, ctrl: 1'b0, kind: serial_irq_pkg::KIND_ENABLE};
      unique case (addr)
         serial_irq_pkg::SERIAL1_IRQ_ENABLE_ADDR: begin
            d.ctrl = 1'b0;
         end
         serial_irq_pkg::SERIAL2_IRQ_ENABLE_ADDR: begin
            d.ctrl = 1'b1;
         end
         serial_irq_pkg::SERIAL1_IRQ_TRIGGER_MODE_ADDR: begin
            d.kind = serial_irq_pkg::KIND_MODE;
         end
         serial_irq_pkg::SERIAL2_IRQ_TRIGGER_MODE_ADDR: begin
            d.ctrl = 1'b1;
            d.kind = serial_irq_pkg::KIND_MODE;
         end
         serial_irq_pkg::SERIAL1_IRQ_PENDING_ADDR: begin
            d.kind = serial_irq_pkg::KIND_PENDING;
         end
         serial_irq_pkg::SERIAL2_IRQ_PENDING_ADDR: begin
            d.ctrl = 1'b1;
            d.kind = serial_irq_pkg::KIND_PENDING;
         end
         default: begin
            d.hit = 1'b0;
         end
      endcase
      return d;
   endfunction : decode_addr

   // Merge written byte lanes into a 15-bit field; bits above 14 are dropped
   function automatic logic [14:0] merge_lanes(input logic [14:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
      logic [14:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = data[7:0];
      end
      if (strb[1]) begin
         r[14:8] = data[14:8];
      end
      return r;
   endfunction : merge_lanes

   // Bus write state
   serial_irq_pkg::wr_state_type wr_state_reg, wr_state_next;
   logic aw_held_reg, aw_held_next;
   logic w_held_reg, w_held_next;
   logic [31:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic wr_commit;
   serial_irq_pkg::decode_type wr_dec;

   // Bus read state
   serial_irq_pkg::rd_state_type rd_state_reg, rd_state_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   serial_irq_pkg::decode_type rd_dec;

   // Interrupt state
   logic [1:0][14:0] enable_reg, enable_next;
   logic [1:0][2:0] mode_reg, mode_next;
   logic [1:0][14:0] pending_reg, pending_next;
   logic [1:0][2:0] prev_reg, prev_next;
   logic [1:0] irq_reg, irq_next;
   logic [1:0][14:0] set_vec;

   // Write channel: address and data are taken in either order, then answered
   always_comb begin
      wr_state_next = wr_state_reg;
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      awready_next = awready_reg;
      wready_next = wready_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      wr_commit = 1'b0;
      wr_dec = decode_addr(awaddr_reg);
      unique case (wr_state_reg)
         serial_irq_pkg::WR_WAIT: begin
            if (s_axi_awvalid && awready_reg) begin
               aw_held_next = 1'b1;
               awaddr_next = s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_reg) begin
               w_held_next = 1'b1;
               wdata_next = s_axi_wdata;
               wstrb_next = s_axi_wstrb;
            end
            if (aw_held_reg && w_held_reg) begin
               // Both halves held: apply the write and answer in the same edge
               wr_commit = 1'b1;
               aw_held_next = 1'b0;
               w_held_next = 1'b0;
               bvalid_next = 1'b1;
               bresp_next = wr_dec.hit ? serial_irq_pkg::RESP_OKAY : serial_irq_pkg::RESP_SLVERR;
               wr_state_next = serial_irq_pkg::WR_RESP;
            end
            // Ready drops once a half is held so the master cannot send a second one
            awready_next = !aw_held_next && !wr_commit;
            wready_next = !w_held_next && !wr_commit;
         end
         serial_irq_pkg::WR_RESP: begin
            if (s_axi_bready) begin
               bvalid_next = 1'b0;
               awready_next = 1'b1;
               wready_next = 1'b1;
               wr_state_next = serial_irq_pkg::WR_WAIT;
            end
         end
      endcase
   end

   // Write channel registers
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_state_reg <= serial_irq_pkg::WR_WAIT;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 32'h0000_0000;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= serial_irq_pkg::RESP_OKAY;
      end else if (ce) begin
         wr_state_reg <= wr_state_next;
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
      end
   end

   // Read channel: data is captured at the address handshake
   always_comb begin
      rd_state_next = rd_state_reg;
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      rd_dec = decode_addr(s_axi_araddr);
      unique case (rd_state_reg)
         serial_irq_pkg::RD_WAIT: begin
            arready_next = 1'b1;
            if (s_axi_arvalid && arready_reg) begin
               arready_next = 1'b0;
               rvalid_next = 1'b1;
               rresp_next = rd_dec.hit ? serial_irq_pkg::RESP_OKAY : serial_irq_pkg::RESP_SLVERR;
               rdata_next = 32'h0000_0000; // Upper bits always read zero
               if (rd_dec.hit) begin
                  unique case (rd_dec.kind)
                     serial_irq_pkg::KIND_ENABLE: rdata_next[14:0] = enable_reg[rd_dec.ctrl];
                     serial_irq_pkg::KIND_MODE: rdata_next[2:0] = mode_reg[rd_dec.ctrl];
                     serial_irq_pkg::KIND_PENDING: rdata_next[14:0] = pending_reg[rd_dec.ctrl];
                  endcase
               end
               rd_state_next = serial_irq_pkg::RD_DATA;
            end
         end
         serial_irq_pkg::RD_DATA: begin
            if (s_axi_rready) begin
               rvalid_next = 1'b0;
               arready_next = 1'b1;
               rd_state_next = serial_irq_pkg::RD_WAIT;
            end
         end
      endcase
   end

   // Read channel registers
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_state_reg <= serial_irq_pkg::RD_WAIT;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= serial_irq_pkg::RESP_OKAY;
      end else if (ce) begin
         rd_state_reg <= rd_state_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // Per-controller set terms; strobe sources count as levels, mode bits pick for the rest
   for (genvar c = 0; c < serial_irq_pkg::NUM_CTRL; c++) begin : g_set
      assign set_vec[c] = serial_src[c] & {serial_irq_pkg::STROBE_LEVEL,
                                           mode_reg[c] | ~prev_reg[c]};
   end

   // Enable, mode and pending updates; a pending flag is cleared by writing one
   always_comb begin
      enable_next = enable_reg;
      mode_next = mode_reg;
      prev_next = prev_reg;
      for (int c = 0; c < serial_irq_pkg::NUM_CTRL; c++) begin
         // Remember the low three conditions for edge detection
         prev_next[c] = serial_src[c][2:0];
         pending_next[c] = pending_reg[c] | set_vec[c];
         if (wr_commit && wr_dec.hit && wr_dec.ctrl == c[0]) begin
            unique case (wr_dec.kind)
               serial_irq_pkg::KIND_ENABLE: begin
                  enable_next[c] = merge_lanes(enable_reg[c], wdata_reg, wstrb_reg);
               end
               serial_irq_pkg::KIND_MODE: begin
                  if (wstrb_reg[0]) begin
                     mode_next[c] = wdata_reg[2:0];
                  end
               end
               serial_irq_pkg::KIND_PENDING: begin
                  // A new event in the clearing cycle wins over the clear
                  pending_next[c] = (pending_reg[c] & ~merge_lanes(15'h0000, wdata_reg,
                                     wstrb_reg)) | set_vec[c];
               end
            endcase
         end
         irq_next[c] = |(pending_reg[c] & enable_reg[c]);
      end
   end

   // Interrupt state registers
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int c = 0; c < serial_irq_pkg::NUM_CTRL; c++) begin
            enable_reg[c] <= serial_irq_pkg::ENABLE_RESET;
            mode_reg[c] <= serial_irq_pkg::MODE_RESET;
            pending_reg[c] <= serial_irq_pkg::PENDING_RESET;
            prev_reg[c] <= serial_irq_pkg::MODE_RESET;
         end
         irq_reg <= 2'h0;
      end else if (ce) begin
         enable_reg <= enable_next;
         mode_reg <= mode_next;
         pending_reg <= pending_next;
         prev_reg <= prev_next;
         irq_reg <= irq_next;
      end
   end

   // Outputs straight from flip-flops
   assign serial_irq = irq_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // Checks on the gating, trigger modes and register behaviour
   a_parity_gate: assert property (@(posedge clk) disable iff (rst)
      ce && pending_reg[0][14] && enable_reg[0][14] |=> serial_irq[0])
      else $error("parity error enabled but no interrupt");
   a_framing_gate: assert property (@(posedge clk) disable iff (rst)
      ce && pending_reg[1][13] && enable_reg[1][13] |=> serial_irq[1])
      else $error("framing error enabled but no interrupt");
   a_tx_dma_gate: assert property (@(posedge clk) disable iff (rst)
      ce && |(pending_reg[0][12:11] & enable_reg[0][12:11]) |=> serial_irq[0])
      else $error("transmit buffer unloaded enabled but no interrupt");
   a_rx_dma_gate: assert property (@(posedge clk) disable iff (rst)
      ce && |(pending_reg[1][10:9] & enable_reg[1][10:9]) |=> serial_irq[1])
      else $error("receive buffer unloaded enabled but no interrupt");
   a_noack_gate: assert property (@(posedge clk) disable iff (rst)
      ce && pending_reg[1] == 15'h0100 && !enable_reg[1][8] |=> !serial_irq[1])
      else $error("disabled not-acknowledge raised the interrupt");
   a_cmd_done_gate: assert property (@(posedge clk) disable iff (rst)
      ce && pending_reg[1][7] && enable_reg[1][7] |=> serial_irq[1])
      else $error("command done enabled but no interrupt");
   a_tx_done_gate: assert property (@(posedge clk) disable iff (rst)
      ce && pending_reg[1] == 15'h0040 && !enable_reg[1][6] |=> !serial_irq[1])
      else $error("disabled transmit done raised the interrupt");
   a_rx_done_gate: assert property (@(posedge clk) disable iff (rst)
      ce && pending_reg[1][5] && enable_reg[1][5] |=> serial_irq[1])
      else $error("receive done enabled but no interrupt");
   a_underrun_gate: assert property (@(posedge clk) disable iff (rst)
      ce && pending_reg[0][4] && enable_reg[0][4] |=> serial_irq[0])
      else $error("underrun enabled but no interrupt");
   a_overrun_gate: assert property (@(posedge clk) disable iff (rst)
      ce && pending_reg[1][3] && enable_reg[1][3] |=> serial_irq[1])
      else $error("overrun enabled but no interrupt");
   a_tx_space_idle: assert property (@(posedge clk) disable iff (rst)
      ce && |(pending_reg[0][2:1] & enable_reg[0][2:1]) |=> serial_irq[0])
      else $error("transmit space or idle enabled but no interrupt");
   a_rx_data_gate: assert property (@(posedge clk) disable iff (rst)
      ce && pending_reg[1] == 15'h0001 && !enable_reg[1][0] |=> !serial_irq[1])
      else $error("disabled receive data raised the interrupt");
   a_idle_level: assert property (@(posedge clk) disable iff (rst)
      ce && mode_reg[0][2] && serial_src[0].tx_idle_irq |=> pending_reg[0][2])
      else $error("level transmitter idle did not hold its flag");
   a_space_edge: assert property (@(posedge clk) disable iff (rst)
      ce && !mode_reg[1][1] && serial_src[1].tx_space_irq && !prev_reg[1][1]
      |=> pending_reg[1][1])
      else $error("rising transmit space did not set its flag");
   a_rx_edge_hold: assert property (@(posedge clk) disable iff (rst)
      ce && !mode_reg[0][0] && prev_reg[0][0] && !pending_reg[0][0] |=> !pending_reg[0][0])
      else $error("edge receive data set its flag without a rise");
   a_enable_reset: assert property (@(posedge clk)
      $fell(rst) |-> enable_reg == 30'h0000_0000)
      else $error("enable registers not zero after reset");
   a_mode_reset: assert property (@(posedge clk)
      $fell(rst) |-> mode_reg == 6'h00 && !serial_irq[0] && !serial_irq[1])
      else $error("mode registers not zero after reset");
   a_strobe_sets: assert property (@(posedge clk) disable iff (rst)
      ce && serial_src[1].twowire_noack_irq ##1 ce [*2] |-> pending_reg[1][8])
      else $error("not-acknowledge strobe did not set bit 8");
   a_irq_drops: assert property (@(posedge clk) disable iff (rst)
      ce && (pending_reg[1] & enable_reg[1]) == 15'h0000 |=> !serial_irq[1])
      else $error("interrupt high without an enabled pending flag");
   a_level_rearm: assert property (@(posedge clk) disable iff (rst)
      ce && mode_reg[0][0] && serial_src[0].rx_data_irq [*2] |=> pending_reg[0][0])
      else $error("level receive data flag not re-set");
   a_upper_zero: assert property (@(posedge clk) disable iff (rst)
      s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h00000)
      else $error("upper register bits read nonzero");

endmodule : serial_irq_gate
`default_nettype wire

// ---- testbench/irq_sink.sv ----
// Top-level interrupt controller stand-in for the serial interrupt gate.
// Assumes software raises top_en only after the second level is set up.
`timescale 1ns/1ns
`default_nettype none
module irq_sink (
   input wire logic clk,
   input wire logic rst,
   input wire logic top_en,
   input wire logic [1:0] serial_irq,
   output logic [7:0] taken_cnt
);
   logic last_reg;
   // Counts requests of controller 1 seen while the top level is open
   always_ff @(posedge clk) begin
      if (rst) begin
         last_reg <= 1'b0;
         taken_cnt <= 8'h00;
      end else begin
         last_reg <= serial_irq[0];
         if (top_en && serial_irq[0] && !last_reg) taken_cnt <= taken_cnt + 8'h01;
      end
   end
endmodule : irq_sink
`default_nettype wire

// ---- testbench/test_serial_irq_gate.sv ----
// Self-checking bench for the serial interrupt gate over AXI4-Lite.
// Assumes ce is high except in the freeze scenario; the far side is the irq_sink model.
`timescale 1ns/1ns
`default_nettype none
module test_serial_irq_gate;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, top_en = 1'b0;
   serial_irq_pkg::serial_src_type [1:0] src = '0;
   logic [1:0] serial_irq, bresp, rresp;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] taken_cnt;
   int error_cnt = 0, compares = 0;
   serial_irq_gate DUT (.clk(clk), .rst(rst), .ce(ce), .serial_src(src),
      .serial_irq(serial_irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   irq_sink sink (.clk(clk), .rst(rst), .top_en(top_en), .serial_irq(serial_irq),
      .taken_cnt(taken_cnt));
   always #20 clk = ~clk;
   task automatic chk_data(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_data
   task automatic chk_bits(input string what, input logic [1:0] exp, input logic [1:0] got);
      chk_data(what, {30'h0, exp}, {30'h0, got});
   endtask : chk_bits
   // Offers address and data together and drops each as it is taken
   task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic wr_ok(input logic [31:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk_bits("write resp", serial_irq_pkg::RESP_OKAY, r);
   endtask : wr_ok
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk_data("read data", exp, d);
      chk_bits("read resp", er, r);
   endtask : rd_chk
   // Reset values, field widths and an unmapped place
   task automatic t_regs;
      logic [1:0] r;
      rd_chk(serial_irq_pkg::SERIAL1_IRQ_ENABLE_ADDR, 32'h0, 2'h0);
      rd_chk(serial_irq_pkg::SERIAL2_IRQ_ENABLE_ADDR, 32'h0, 2'h0);
      rd_chk(serial_irq_pkg::SERIAL1_IRQ_TRIGGER_MODE_ADDR, 32'h0, 2'h0);
      rd_chk(serial_irq_pkg::SERIAL2_IRQ_TRIGGER_MODE_ADDR, 32'h0, 2'h0);
      wr_ok(serial_irq_pkg::SERIAL2_IRQ_ENABLE_ADDR, 32'hffffffff);
      rd_chk(serial_irq_pkg::SERIAL2_IRQ_ENABLE_ADDR, 32'h00007fff, 2'h0);
      wr_ok(serial_irq_pkg::SERIAL2_IRQ_TRIGGER_MODE_ADDR, 32'hffffffff);
      rd_chk(serial_irq_pkg::SERIAL2_IRQ_TRIGGER_MODE_ADDR, 32'h00000007, 2'h0);
      wr(32'h4000a850, 32'hffffffff, r);
      chk_bits("unmapped write", serial_irq_pkg::RESP_SLVERR, r);
      rd_chk(32'h4000a850, 32'h0, serial_irq_pkg::RESP_SLVERR);
      wr_ok(serial_irq_pkg::SERIAL2_IRQ_ENABLE_ADDR, 32'h0);
      wr_ok(serial_irq_pkg::SERIAL2_IRQ_TRIGGER_MODE_ADDR, 32'h0);
   endtask : t_regs
   // Each source alone: even ones enabled on controller 1 only, odd ones on controller 2 only
   task automatic t_sources;
      for (int i = 0; i < 15; i++) begin
         wr_ok(serial_irq_pkg::SERIAL1_IRQ_ENABLE_ADDR, (i % 2 == 0) ? 32'h1 << i : 32'h0);
         wr_ok(serial_irq_pkg::SERIAL2_IRQ_ENABLE_ADDR, (i % 2 == 1) ? 32'h1 << i : 32'h0);
         if (i == 0) top_en <= 1'b1;
         src <= {2{15'h1 << i}};
         @(posedge clk);
         src <= '0;
         repeat (3) @(posedge clk);
         chk_bits("irq", (i % 2 == 0) ? 2'h1 : 2'h2, serial_irq);
         rd_chk(serial_irq_pkg::SERIAL2_IRQ_PENDING_ADDR, 32'h1 << i, 2'h0);
         wr_ok(serial_irq_pkg::SERIAL1_IRQ_PENDING_ADDR, 32'h1 << i);
         wr_ok(serial_irq_pkg::SERIAL2_IRQ_PENDING_ADDR, 32'h1 << i);
         repeat (2) @(posedge clk);
         chk_bits("irq off", 2'h0, serial_irq);
      end
      chk_data("taken", 32'h0000_0008, {24'h0, taken_cnt});
   endtask : t_sources
   // A held condition re-sets its flag only in level mode
   task automatic t_modes;
      for (int b = 0; b < 3; b++) begin
         for (int lvl = 0; lvl < 2; lvl++) begin
            wr_ok(serial_irq_pkg::SERIAL1_IRQ_TRIGGER_MODE_ADDR, lvl << b);
            src[0] <= 15'h1 << b;
            repeat (3) @(posedge clk);
            wr_ok(serial_irq_pkg::SERIAL1_IRQ_PENDING_ADDR, 32'h1 << b);
            rd_chk(serial_irq_pkg::SERIAL1_IRQ_PENDING_ADDR, lvl << b, 2'h0);
            src <= '0;
            wr_ok(serial_irq_pkg::SERIAL1_IRQ_PENDING_ADDR, 32'h1 << b);
         end
      end
   endtask : t_modes
   // A strobe seen only while ce is low must leave no flag behind
   task automatic t_freeze;
      ce <= 1'b0;
      src[0] <= 15'h0008;
      repeat (2) @(posedge clk);
      src <= '0;
      ce <= 1'b1;
      rd_chk(serial_irq_pkg::SERIAL1_IRQ_PENDING_ADDR, 32'h0000_0000, 2'h0);
   endtask : t_freeze
   task automatic summarize;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize
   // Whole run is well under 4000 cycles
   initial begin
      #400000;
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_sources();
      t_modes();
      t_freeze();
      summarize();
   end
endmodule : test_serial_irq_gate
`default_nettype wire
